// >>> vpcr_pkg.sv
package vpcr_pkg;

	// Command codes of the three configuration words
	localparam logic [7:0] VPCR_CODE_OVERSHOOT = 8'h40;
	localparam logic [7:0] VPCR_CODE_THERMAL = 8'h43;
	localparam logic [7:0] VPCR_CODE_SYSTEM = 8'h44;

	// Writable bits of each word; every other bit stores nothing
	localparam logic [15:0] VPCR_MASK_OVERSHOOT = 16'h3FFF;
	localparam logic [15:0] VPCR_MASK_THERMAL = 16'h01FF;
	localparam logic [15:0] VPCR_MASK_SYSTEM = 16'hFFDF;

	// Values after reset
	localparam logic [15:0] VPCR_RESET_OVERSHOOT = 16'h0000;
	localparam logic [15:0] VPCR_RESET_THERMAL = 16'h0000;
	localparam logic [15:0] VPCR_RESET_SYSTEM = 16'h0000;

	// Field positions, overshoot-reduction word
	localparam int VPCR_OFF_TIME_LSB = 8;
	localparam int VPCR_OFF_TIME_MSB = 13;
	localparam int VPCR_SPACING_LSB = 0;
	localparam int VPCR_SPACING_MSB = 7;

	// Field positions, thermal-release word
	localparam int VPCR_THERM_TYPE_BIT = 8;
	localparam int VPCR_EXT_REL_LSB = 4;
	localparam int VPCR_EXT_REL_MSB = 7;
	localparam int VPCR_INT_REL_LSB = 0;
	localparam int VPCR_INT_REL_MSB = 3;

	// Field positions, system word
	localparam int VPCR_DUV_LEVEL_LSB = 12;
	localparam int VPCR_DUV_LEVEL_MSB = 15;
	localparam int VPCR_DUV_EN_BIT = 11;
	localparam int VPCR_OC_MASK_BIT = 10;
	localparam int VPCR_AUV_DIS_BIT = 9;
	localparam int VPCR_OC_FILT_LSB = 7;
	localparam int VPCR_OC_FILT_MSB = 8;
	localparam int VPCR_AC_START_BIT = 6;
	localparam int VPCR_PHASE_RES_BIT = 4;
	localparam int VPCR_TOTAL_RES_BIT = 3;
	localparam int VPCR_GAIN_LSB = 0;
	localparam int VPCR_GAIN_MSB = 2;

	// Overcurrent filter timing
	localparam int VPCR_CLK_PERIOD_NS = 10;
	localparam int VPCR_OC_FILT_800_NS = 800;
	localparam int VPCR_OC_FILT_1000_NS = 1000;
	localparam int VPCR_OC_FILT_1200_NS = 1200;
	localparam int VPCR_OC_FILT_800_CYC =
		(VPCR_OC_FILT_800_NS + VPCR_CLK_PERIOD_NS - 1) / VPCR_CLK_PERIOD_NS;
	localparam int VPCR_OC_FILT_1000_CYC =
		(VPCR_OC_FILT_1000_NS + VPCR_CLK_PERIOD_NS - 1) / VPCR_CLK_PERIOD_NS;
	localparam int VPCR_OC_FILT_1200_CYC =
		(VPCR_OC_FILT_1200_NS + VPCR_CLK_PERIOD_NS - 1) / VPCR_CLK_PERIOD_NS;
	localparam int VPCR_OC_CNT_W = 7;
	localparam logic [1:0] VPCR_OC_FORCE_HIGH = 2'h3;

	// One word transaction already decoded from the serial link
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [15:0] data;
	} vpcr_cmd_type;

	// Answer to a word transaction
	typedef struct packed {
		logic valid;
		logic nack;
		logic [15:0] data;
	} vpcr_resp_type;

endpackage : vpcr_pkg

// >>> vpcr_oc_filter.sv
`timescale 1ns/1ps
module vpcr_oc_filter (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic oc_raw,
	input wire logic [1:0] filter_sel,
	output logic oc_filtered
);
	import vpcr_pkg::*;

	logic [VPCR_OC_CNT_W-1:0] count;
	logic [VPCR_OC_CNT_W-1:0] next_count;
	logic next_oc_filtered;

	function automatic logic [VPCR_OC_CNT_W-1:0] filter_cycles(input logic [1:0] sel);
		unique case (sel)
			2'h0: filter_cycles = VPCR_OC_CNT_W'(VPCR_OC_FILT_800_CYC);
			2'h1: filter_cycles = VPCR_OC_CNT_W'(VPCR_OC_FILT_1000_CYC);
			default: filter_cycles = VPCR_OC_CNT_W'(VPCR_OC_FILT_1200_CYC);
		endcase
	endfunction : filter_cycles

	// A single low sample restarts the wait, so short spikes never pass
	always_comb begin
		next_count = count;
		next_oc_filtered = 1'b0;
		if (filter_sel == VPCR_OC_FORCE_HIGH) begin
			next_count = '0;
			next_oc_filtered = 1'b1;
		end else if (!oc_raw) begin
			next_count = '0;
		end else if (count >= filter_cycles(filter_sel) - VPCR_OC_CNT_W'(1)) begin
			next_oc_filtered = 1'b1;
		end else begin
			next_count = count + VPCR_OC_CNT_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			count <= '0;
			oc_filtered <= 1'b0;
		end else begin
			count <= next_count;
			oc_filtered <= next_oc_filtered;
		end
	end

endmodule : vpcr_oc_filter

// >>> vpcr_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Unused bits of the three words ignore writes and read back as zero.
// - Bits 13:8 of the overshoot word give the minimum off-time in 5 ns steps.
// - Bits 7:0 of the overshoot word give the least spacing of two overshoot events in 5 ns steps.
// - Bit 8 of the thermal word picks the thermistor: 0 positive, 1 negative coefficient.
// - Bits 7:4 of the thermal word hold the external-sensor warning release level.
// - Bits 3:0 of the thermal word hold the internal-sensor warning release level, 16 C a count.
// - Bits 15:12 of the system word set the digital undervoltage level, 32 mV a count.
// - Bit 11 of the system word enables the digital undervoltage protection.
// - Bit 10 of the system word masks analog undervoltage while raw overcurrent is high.
// - Bit 9 of the system word set to one turns analog undervoltage protection off.
// - Bits 8:7 pick an 800, 1000 or 1200 ns overcurrent filter, or force it high on 11.
// - Digital undervoltage trips only when filtered overcurrent and the level compare agree.
// - Bit 6 starts the AC droop loop at soft-start when one, after power-on reset when zero.
// - Bit 4 halves per-phase current resolution to double its range.
// - Bit 3 does the same for total current, its protection, warning and shedding levels.
// - Bits 2:0 store the power-stage sense-gain code, driven out on power_stage_sense_gain_code.
module vpcr_regs #(
	parameter int VOUT_W = 8
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input vpcr_pkg::vpcr_cmd_type cmd,
	output vpcr_pkg::vpcr_resp_type resp,
	input wire logic oc_raw,
	input wire logic [VOUT_W-1:0] vout_level,
	input wire logic analog_uv_detect,
	input wire logic soft_start_begun,
	input wire logic por_done,
	output logic [5:0] overshoot_min_off_time,
	output logic [7:0] overshoot_event_spacing,
	output logic thermistor_type_select,
	output logic [3:0] ext_temp_warn_release_level,
	output logic [3:0] int_temp_warn_release_level,
	output logic phase_current_half_res,
	output logic total_current_half_res,
	output logic [2:0] power_stage_sense_gain_code,
	output logic digital_undervolt_trip,
	output logic analog_undervolt_trip,
	output logic ac_droop_active
);
	import vpcr_pkg::*;

	logic [15:0] overshoot_reduction_timing;
	logic [15:0] thermal_warning_release_setup;
	logic [15:0] system_protection_setup;
	logic [15:0] next_overshoot_reduction_timing;
	logic [15:0] next_thermal_warning_release_setup;
	logic [15:0] next_system_protection_setup;
	vpcr_resp_type next_resp;
	logic oc_filtered;
	logic digital_uv_compare;
	logic next_digital_undervolt_trip;
	logic next_analog_undervolt_trip;
	logic next_ac_droop_active;

	// Command decode and word storage
	always_comb begin
		next_overshoot_reduction_timing = overshoot_reduction_timing;
		next_thermal_warning_release_setup = thermal_warning_release_setup;
		next_system_protection_setup = system_protection_setup;
		next_resp = '0;
		if (cmd.valid) begin
			next_resp.valid = 1'b1;
			unique case (cmd.code)
				VPCR_CODE_OVERSHOOT: begin
					if (cmd.write)
						next_overshoot_reduction_timing = cmd.data & VPCR_MASK_OVERSHOOT;
					else
						next_resp.data = overshoot_reduction_timing;
				end
				VPCR_CODE_THERMAL: begin
					if (cmd.write)
						next_thermal_warning_release_setup = cmd.data & VPCR_MASK_THERMAL;
					else
						next_resp.data = thermal_warning_release_setup;
				end
				VPCR_CODE_SYSTEM: begin
					if (cmd.write)
						next_system_protection_setup = cmd.data & VPCR_MASK_SYSTEM;
					else
						next_resp.data = system_protection_setup;
				end
				default: next_resp.nack = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			overshoot_reduction_timing <= VPCR_RESET_OVERSHOOT;
			thermal_warning_release_setup <= VPCR_RESET_THERMAL;
			system_protection_setup <= VPCR_RESET_SYSTEM;
			resp <= '0;
		end else begin
			overshoot_reduction_timing <= next_overshoot_reduction_timing;
			thermal_warning_release_setup <= next_thermal_warning_release_setup;
			system_protection_setup <= next_system_protection_setup;
			resp <= next_resp;
		end
	end

	// Fields drive the rest of the controller straight from the words
	assign overshoot_min_off_time =
		overshoot_reduction_timing[VPCR_OFF_TIME_MSB:VPCR_OFF_TIME_LSB];
	assign overshoot_event_spacing =
		overshoot_reduction_timing[VPCR_SPACING_MSB:VPCR_SPACING_LSB];
	assign thermistor_type_select = thermal_warning_release_setup[VPCR_THERM_TYPE_BIT];
	assign ext_temp_warn_release_level =
		thermal_warning_release_setup[VPCR_EXT_REL_MSB:VPCR_EXT_REL_LSB];
	assign int_temp_warn_release_level =
		thermal_warning_release_setup[VPCR_INT_REL_MSB:VPCR_INT_REL_LSB];
	assign phase_current_half_res = system_protection_setup[VPCR_PHASE_RES_BIT];
	assign total_current_half_res = system_protection_setup[VPCR_TOTAL_RES_BIT];
	assign power_stage_sense_gain_code =
		system_protection_setup[VPCR_GAIN_MSB:VPCR_GAIN_LSB];

	vpcr_oc_filter u_oc_filter (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.oc_raw(oc_raw),
		.filter_sel(system_protection_setup[VPCR_OC_FILT_MSB:VPCR_OC_FILT_LSB]),
		.oc_filtered(oc_filtered)
	);

	// Output voltage in 32 mV counts against the 4-bit level
	assign digital_uv_compare = vout_level <
		VOUT_W'(system_protection_setup[VPCR_DUV_LEVEL_MSB:VPCR_DUV_LEVEL_LSB]);

	// Protection decisions, one register stage to keep outputs glitch free
	always_comb begin
		next_digital_undervolt_trip = system_protection_setup[VPCR_DUV_EN_BIT]
			& oc_filtered & digital_uv_compare;
		// Raw overcurrent masks, not the filtered one, so the mask acts at once
		next_analog_undervolt_trip = analog_uv_detect
			& ~system_protection_setup[VPCR_AUV_DIS_BIT]
			& ~(system_protection_setup[VPCR_OC_MASK_BIT] & oc_raw);
		next_ac_droop_active = system_protection_setup[VPCR_AC_START_BIT]
			? soft_start_begun : por_done;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			digital_undervolt_trip <= 1'b0;
			analog_undervolt_trip <= 1'b0;
			ac_droop_active <= 1'b0;
		end else begin
			digital_undervolt_trip <= next_digital_undervolt_trip;
			analog_undervolt_trip <= next_analog_undervolt_trip;
			ac_droop_active <= next_ac_droop_active;
		end
	end

endmodule : vpcr_regs

// >>> vpcr_host.sv
`timescale 1ns/1ps
module vpcr_host (
	input wire logic sys_clk,
	output vpcr_pkg::vpcr_cmd_type cmd,
	input vpcr_pkg::vpcr_resp_type resp
);
	import vpcr_pkg::*;
	initial cmd = '0;
	// One word per pulse; idle fields inverted so stale values never pass
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q, output logic nk);
		@(posedge sys_clk);
		#1 cmd = '{1'b1, w, c, d};
		@(posedge sys_clk);
		#1 q = resp.data;
		nk = resp.valid === 1'b1 ? resp.nack : 1'bx;
		cmd = '{1'b0, ~w, ~c, ~d};
	endtask : xfer
endmodule : vpcr_host

// >>> vpcr_regs_sva.sv
`timescale 1ns/1ps
module vpcr_regs_sva #(
	parameter int VOUT_W = 8
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input vpcr_pkg::vpcr_cmd_type cmd,
	input vpcr_pkg::vpcr_resp_type resp,
	input wire logic oc_raw,
	input wire logic [VOUT_W-1:0] vout_level,
	input wire logic analog_uv_detect,
	input wire logic soft_start_begun,
	input wire logic por_done,
	input wire logic [5:0] overshoot_min_off_time,
	input wire logic [7:0] overshoot_event_spacing,
	input wire logic thermistor_type_select,
	input wire logic [3:0] ext_temp_warn_release_level,
	input wire logic [3:0] int_temp_warn_release_level,
	input wire logic phase_current_half_res,
	input wire logic total_current_half_res,
	input wire logic [2:0] power_stage_sense_gain_code,
	input wire logic digital_undervolt_trip,
	input wire logic analog_undervolt_trip,
	input wire logic ac_droop_active
);
	import vpcr_pkg::*;
	// Shadow of the system word, needed because its control bits are not on ports
	logic [15:0] sys_w;
	logic [15:0] next_sys_w;
	logic known;
	assign known = cmd.code inside {VPCR_CODE_OVERSHOOT, VPCR_CODE_THERMAL, VPCR_CODE_SYSTEM};
	always_comb begin
		next_sys_w = sys_w;
		if (cmd.valid && cmd.write && cmd.code == VPCR_CODE_SYSTEM) begin
			next_sys_w = cmd.data & 16'hFFDF;
		end
	end
	always_ff @(posedge sys_clk) begin
		sys_w <= nrst ? next_sys_w : 16'h0000;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_wr(logic [7:0] c);
		cmd.valid && cmd.write && cmd.code == c;
	endsequence
	sequence s_rd(logic [7:0] c);
		cmd.valid && !cmd.write && cmd.code == c;
	endsequence
	// Forced filter with enable and level met; trip follows after filter and output stages
	sequence s_forced_uv;
		sys_w[11] && sys_w[8:7] == 2'b11 && vout_level < sys_w[15:12];
	endsequence
	a_system_readback: assert property (s_rd(VPCR_CODE_SYSTEM) |=> resp.data == sys_w)
		else $error("system word read back wrong");
	a_forced_trip: assert property (s_forced_uv ##1 s_forced_uv |=> digital_undervolt_trip)
		else $error("forced overcurrent did not trip digital undervoltage");
	a_resp_next: assert property (cmd.valid |=> resp.valid)
		else $error("no answer one cycle after a request");
	a_unknown_nack: assert property (cmd.valid && !known |=> resp.nack && resp.data == 16'h0000)
		else $error("unknown code not refused");
	a_overshoot_fields: assert property (s_wr(VPCR_CODE_OVERSHOOT) |=>
		{overshoot_min_off_time, overshoot_event_spacing} == $past(cmd.data[13:0]))
		else $error("overshoot fields wrong after write");
	a_thermal_fields: assert property (s_wr(VPCR_CODE_THERMAL) |=> {thermistor_type_select,
		ext_temp_warn_release_level, int_temp_warn_release_level} == $past(cmd.data[8:0]))
		else $error("thermal fields wrong after write");
	a_system_fields: assert property (s_wr(VPCR_CODE_SYSTEM) |=> {phase_current_half_res,
		total_current_half_res, power_stage_sense_gain_code} == $past(cmd.data[4:0]))
		else $error("system fields wrong after write");
	a_analog_trip: assert property ($past(nrst) |-> analog_undervolt_trip ==
		$past(analog_uv_detect && !sys_w[9] && !(sys_w[10] && oc_raw)))
		else $error("analog trip does not follow its mask bits");
	a_digital_gate: assert property (digital_undervolt_trip |->
		$past(sys_w[11] && vout_level < sys_w[15:12])) else $error("digital trip without cause");
	a_droop_start: assert property ($rose(ac_droop_active) |->
		$past(sys_w[6] ? soft_start_begun : por_done)) else $error("droop started without cause");
endmodule : vpcr_regs_sva
bind vpcr_regs vpcr_regs_sva #(.VOUT_W(VOUT_W)) u_sva (.sys_clk, .nrst, .cmd, .resp, .oc_raw,
	.vout_level, .analog_uv_detect, .soft_start_begun, .por_done, .overshoot_min_off_time,
	.overshoot_event_spacing, .thermistor_type_select, .ext_temp_warn_release_level,
	.int_temp_warn_release_level, .phase_current_half_res, .total_current_half_res,
	.power_stage_sense_gain_code, .digital_undervolt_trip, .analog_undervolt_trip, .ac_droop_active);

// >>> tb.sv
`timescale 1ns/1ps
module tb;
	import vpcr_pkg::*;
	logic sys_clk, nrst, oc_raw, analog_uv_detect, soft_start_begun, por_done;
	logic [7:0] vout_level;
	vpcr_cmd_type cmd;
	vpcr_resp_type resp;
	logic [5:0] overshoot_min_off_time;
	logic [7:0] overshoot_event_spacing;
	logic [3:0] ext_temp_warn_release_level, int_temp_warn_release_level;
	logic [2:0] power_stage_sense_gain_code;
	logic thermistor_type_select, phase_current_half_res, total_current_half_res;
	logic digital_undervolt_trip, analog_undervolt_trip, ac_droop_active;
	int mismatches = 0;
	int check_count = 0;
	vpcr_regs #(.VOUT_W(8)) dut (.sys_clk, .nrst, .cmd, .resp, .oc_raw, .vout_level,
		.analog_uv_detect, .soft_start_begun, .por_done, .overshoot_min_off_time,
		.overshoot_event_spacing, .thermistor_type_select, .ext_temp_warn_release_level,
		.int_temp_warn_release_level, .phase_current_half_res, .total_current_half_res,
		.power_stage_sense_gain_code, .digital_undervolt_trip, .analog_undervolt_trip,
		.ac_droop_active);
	vpcr_host host (.sys_clk, .cmd, .resp);
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [15:0] e);
		logic [15:0] q;
		logic nk;
		host.xfer(w, c, d, q, nk);
		chk("nack", 16'(c != 8'h40 && c != 8'h43 && c != 8'h44), {15'h0, nk});
		chk("data", e, q);
	endtask : acc
	task automatic t_droop();
		acc(1, 8'h44, 16'h0040, 0);
		por_done = 1;
		step(3);
		chk("droop soft", 0, 16'(ac_droop_active));
		soft_start_begun = 1;
		step(3);
		chk("droop soft", 1, 16'(ac_droop_active));
		acc(1, 8'h44, 16'h0000, 0);
		por_done = 0;
		step(3);
		chk("droop por", 0, 16'(ac_droop_active));
		por_done = 1;
		step(3);
		chk("droop por", 1, 16'(ac_droop_active));
	endtask : t_droop
	task automatic t_masks();
		logic [7:0] c [3] = '{8'h40, 8'h43, 8'h44};
		logic [15:0] m [3] = '{16'h3FFF, 16'h01FF, 16'hFFDF};
		for (int i = 0; i < 3; i++) begin
			acc(1, c[i], 16'hFFFF, 0);
			acc(0, c[i], 16'h0000, m[i]);
		end
		acc(1, 8'h40, 16'hEA55, 0);
		acc(1, 8'h43, 16'hFEA5, 0);
		acc(1, 8'h44, 16'h0032, 0);
		chk("overshoot", 16'h2A55, {2'b00, overshoot_min_off_time, overshoot_event_spacing});
		chk("thermal", 16'h00A5, {7'h0, thermistor_type_select, ext_temp_warn_release_level,
			int_temp_warn_release_level});
		chk("system", 16'h0012, {11'h0, phase_current_half_res, total_current_half_res,
			power_stage_sense_gain_code});
		acc(1, 8'h41, 16'hFFFF, 0);
		acc(0, 8'h40, 16'h0000, 16'h2A55);
	endtask : t_masks
	task automatic t_analog();
		analog_uv_detect = 1;
		for (int b = 0; b < 8; b++) begin
			acc(1, 8'h44, {5'h0, 2'(b >> 1), 9'h0}, 0);
			oc_raw = b[0];
			step(2);
			chk("analog trip", 16'(!b[1] && !(b[2] && b[0])), 16'(analog_undervolt_trip));
			chk("digital off", 0, 16'(digital_undervolt_trip));
		end
		oc_raw = 0;
	endtask : t_analog
	task automatic t_digital();
		int k;
		int n [4] = '{80, 100, 120, 0};
		vout_level = 0;
		for (int f = 0; f < 4; f++) begin
			oc_raw = 0;
			acc(1, 8'h44, {4'hF, 1'b1, 2'b00, 2'(f), 7'h0}, 0);
			oc_raw = f < 3;
			k = 0;
			while (digital_undervolt_trip !== 1'b1 && k < 200) begin
				step(1);
				k++;
			end
			chk("filter low", 1, 16'(k >= n[f]));
			chk("filter high", 1, 16'(k <= n[f] + 3));
		end
		vout_level = 8'h0F;
		step(3);
		chk("level trip", 0, 16'(digital_undervolt_trip));
		vout_level = 8'h0E;
		step(3);
		chk("level trip", 1, 16'(digital_undervolt_trip));
		acc(1, 8'h44, {4'hF, 1'b0, 2'b00, 2'h3, 7'h0}, 0);
		step(2);
		chk("digital enable", 0, 16'(digital_undervolt_trip));
	endtask : t_digital
	// Reset in mid-run must bring every word back to its reset value
	task automatic t_reset();
		step(1);
		nrst = 0;
		step(2);
		nrst = 1;
		acc(0, 8'h40, 16'h0000, VPCR_RESET_OVERSHOOT);
		acc(0, 8'h43, 16'h0000, VPCR_RESET_THERMAL);
		acc(0, 8'h44, 16'h0000, VPCR_RESET_SYSTEM);
		chk("trip reset", 0, 16'(digital_undervolt_trip));
	endtask : t_reset
	task automatic summarize();
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	initial begin
		{nrst, oc_raw, analog_uv_detect, soft_start_begun, por_done, vout_level} = '0;
		repeat (6) @(posedge sys_clk);
		#1 nrst = 1;
		t_droop();
		t_masks();
		t_analog();
		t_digital();
		t_reset();
		summarize();
	end
	// Run needs about 400 cycles; generous margin
	initial begin
		#100000;
		mismatches++;
		summarize();
	end
endmodule : tb
